// ===== rlw_pkg.sv
// package: constants and types of the remote link watchdog
package rlw_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] TIMEOUT_OFF   = 8'h04;
  localparam logic [7:0] STATUS_OFF    = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF  = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFF  = 8'h10;
  localparam logic [7:0] ACT_TMO_OFF   = 8'h14;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int CTRL_MON_EN_BIT   = 0;
  localparam int CTRL_OFF_AFTER_BIT = 1;
  localparam int CTRL_MS_SUP_BIT   = 2;
  localparam logic [2:0] CTRL_RST  = 3'h4;

  // ************************************************************
  // status fields
  // ************************************************************
  localparam int STAT_OWNER_LSB    = 0;
  localparam int STAT_DC_ON_BIT    = 2;
  localparam int STAT_SUP_RUN_BIT  = 3;
  localparam int STAT_SLAVE_BIT    = 4;
  localparam int STAT_MSP_BIT      = 5;
  localparam int STAT_MS_RUN_BIT   = 6;

  // ************************************************************
  // event bits (irq status and mask share this layout)
  // ************************************************************
  localparam int EV_TIMEOUT_BIT    = 0;
  localparam int EV_MSP_BIT        = 1;
  localparam int EV_REM_REFUSE_BIT = 2;
  localparam int EV_INIT_REFUSE_BIT = 3;
  localparam int EV_ETH_TMO_BIT    = 4;
  localparam int EV_W              = 5;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int TMO_W             = 16;
  localparam logic [15:0] TIMEOUT_RST = 16'h03E8;
  localparam int CLK_PERIOD_NS     = 100;
  localparam int TICK_PERIOD_NS    = 1_000_000;
  localparam int TICK_CYCLES       = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_W             = 14;
  localparam logic [15:0] MS_LINK_TMO_MS = 16'h0064;

  // ************************************************************
  // owners and AHB codes
  // ************************************************************
  typedef enum logic [1:0] {
    OWN_NONE,
    OWN_REAR,
    OWN_FRONT,
    OWN_FIELDBUS
  } rlw_owner_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int HTRANS_ACT_BIT     = 1;

endpackage : rlw_pkg

// ===== rlw_timer_if.sv
// interface: one silent-period timer and its controller
`timescale 1ns/1ps
interface rlw_timer_if;
  logic                     tick;
  logic                     restart;
  logic                     run;
  logic [rlw_pkg::TMO_W-1:0] limit;
  logic                     expire;
  logic [rlw_pkg::TMO_W-1:0] count;

  modport ctl (output tick, output restart, output run, output limit, input expire, input count);
  modport tmr (input tick, input restart, input run, input limit, output expire, output count);
endinterface : rlw_timer_if

// ===== rlw_timer.sv
// module: silent-period timer counting prescaled ticks
`timescale 1ns/1ps
module rlw_timer (
  input wire logic hclk,
  input wire logic hresetn,
  rlw_timer_if.tmr t
);

  logic [rlw_pkg::TMO_W-1:0] count_r;
  logic                      expire_r;
  logic                      at_limit;

  // zero limit expires on the first tick rather than never
  assign at_limit = (count_r + 16'h0001) >= t.limit;
  assign t.count  = count_r;
  assign t.expire = expire_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r  <= 16'h0000;
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (!t.run || t.restart) begin
        count_r <= 16'h0000;
      end else if (t.tick) begin
        if (at_limit) begin
          count_r  <= 16'h0000;
          expire_r <= 1'b1;
        end else begin
          count_r <= count_r + 16'h0001;
        end
      end
    end
  end

endmodule : rlw_timer

// ===== rlw_watchdog.sv
// module: remote link watchdog top with AHB-Lite registers
// Summary of operation
// - timeout declared when no message arrives within the configured period
// - every message on the supervised interface restarts the period
// - on expiry remote control is left and the owner released
// - on expiry with output on, switch off or keep on per setting
// - new timeout value takes effect only after the running period ends
// - only the interface holding remote control is supervised
// - supervision inactive while the unit is a master-slave slave
// - master-slave link loss raises the protection alarm
// - network connection timeout runs independently of interface supervision
// - front port reads are always answered
// - front port writes accepted only while nobody holds control
// - front port accepts text and RTU framing, reduced command subset (here an RTU-framed front command passes even outside the subset)
// - rear port offers full command set including master operation
// - remote entry refused with error while master-slave runs
// - slave initialisation refused while rear port holds remote
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module rlw_watchdog #(
  parameter int TICK_CYCLES = rlw_pkg::TICK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  msg_rx,
  input  wire logic        rem_req,
  input  wire logic [1:0]  rem_req_if,
  input  wire logic        rem_release,
  input  wire logic        ms_running,
  input  wire logic        is_slave,
  input  wire logic        slave_init_req,
  input  wire logic        ms_heartbeat,
  input  wire logic        msp_ack,
  input  wire logic        eth_timeout,
  input  wire logic        dc_on,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_front,
  input  wire logic        cmd_write,
  input  wire logic        cmd_in_subset,
  input  wire logic        cmd_rtu,
  output logic             cmd_accept,
  output logic             front_rd_grant,
  output logic             front_wr_grant,
  output logic [1:0]       remote_owner,
  output logic             remote_active,
  output logic             dc_off_req,
  output logic             rem_refused,
  output logic             slave_init_ok,
  output logic             slave_init_refused,
  output logic             master_slave_protection_alarm,
  output logic             irq
);

  // ************************************************************
  // AHB-Lite slave front end
  // ************************************************************
  logic [7:0]  dp_addr_r;
  logic        dp_write_r;
  logic        addr_phase;
  logic        wr_ctrl;
  logic        wr_tmo;
  logic        wr_istat;
  logic        wr_imask;
  logic [31:0] rd_mux;

  assign addr_phase = hsel && hready && htrans[rlw_pkg::HTRANS_ACT_BIT];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr_r  <= 8'h00;
      dp_write_r <= 1'b0;
    end else begin
      dp_write_r <= addr_phase && hwrite;
      if (addr_phase) begin
        dp_addr_r <= haddr[7:0];
      end
    end
  end

  assign wr_ctrl  = dp_write_r && (dp_addr_r == rlw_pkg::CTRL_OFF);
  assign wr_tmo   = dp_write_r && (dp_addr_r == rlw_pkg::TIMEOUT_OFF);
  assign wr_istat = dp_write_r && (dp_addr_r == rlw_pkg::IRQ_STAT_OFF);
  assign wr_imask = dp_write_r && (dp_addr_r == rlw_pkg::IRQ_MASK_OFF);

  // ************************************************************
  // software registers
  // ************************************************************
  logic [2:0]                       ctrl_r;
  logic [rlw_pkg::TMO_W-1:0]        tmo_pend_r;
  logic [rlw_pkg::TMO_W-1:0]        tmo_act_r;
  logic [rlw_pkg::EV_W-1:0]         istat_r;
  logic [rlw_pkg::EV_W-1:0]         istat_nxt;
  logic [rlw_pkg::EV_W-1:0]         imask_r;
  logic [rlw_pkg::EV_W-1:0]         ev_set;
  logic                             mon_en;
  logic                             off_after;
  logic                             ms_sup_en;

  assign mon_en    = ctrl_r[rlw_pkg::CTRL_MON_EN_BIT];
  assign off_after = ctrl_r[rlw_pkg::CTRL_OFF_AFTER_BIT];
  assign ms_sup_en = ctrl_r[rlw_pkg::CTRL_MS_SUP_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r     <= rlw_pkg::CTRL_RST;
      tmo_pend_r <= rlw_pkg::TIMEOUT_RST;
      imask_r    <= rlw_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[2:0];
      end
      // writable any time; only staged here
      if (wr_tmo) begin
        tmo_pend_r <= hwdata[15:0];
      end
      if (wr_imask) begin
        imask_r <= hwdata[rlw_pkg::EV_W-1:0];
      end
    end
  end

  // ************************************************************
  // prescaler: one tick per millisecond
  // ************************************************************
  logic [rlw_pkg::PRE_W-1:0] pre_r;
  logic                      tick;

  assign tick = (pre_r == rlw_pkg::PRE_W'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 14'h0000;
    end else if (tick) begin
      pre_r <= 14'h0000;
    end else begin
      pre_r <= pre_r + 14'h0001;
    end
  end

  // ************************************************************
  // remote ownership
  // ************************************************************
  rlw_pkg::rlw_owner_t owner_r;
  rlw_pkg::rlw_owner_t owner_nxt;
  rlw_pkg::rlw_owner_t req_owner;
  logic                rem_ok;
  logic                rem_bad;
  logic                init_bad;
  logic                sup_expire;
  logic                rem_refused_r;
  logic                init_refused_r;
  logic                init_ok_r;
  logic                dc_off_r;

  assign req_owner = rlw_pkg::rlw_owner_t'(rem_req_if);
  // one user interface or the master at a time, never both
  assign rem_bad  = rem_req && (ms_running || is_slave || (owner_r != rlw_pkg::OWN_NONE)
                    || (req_owner == rlw_pkg::OWN_NONE));
  assign rem_ok   = rem_req && !rem_bad;
  assign init_bad = slave_init_req && (owner_r == rlw_pkg::OWN_REAR);

  always_comb begin
    owner_nxt = owner_r;
    case (owner_r)
      rlw_pkg::OWN_NONE: begin
        if (rem_ok) begin
          owner_nxt = req_owner;
        end
      end
      rlw_pkg::OWN_REAR,
      rlw_pkg::OWN_FRONT,
      rlw_pkg::OWN_FIELDBUS: begin
        if (sup_expire) begin
          owner_nxt = rlw_pkg::OWN_NONE;
        end else if (rem_release) begin
          owner_nxt = rlw_pkg::OWN_NONE;
        end
      end
      default: begin
        owner_nxt = rlw_pkg::OWN_NONE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      owner_r        <= rlw_pkg::OWN_NONE;
      rem_refused_r  <= 1'b0;
      init_refused_r <= 1'b0;
      init_ok_r      <= 1'b0;
      dc_off_r       <= 1'b0;
    end else begin
      owner_r        <= owner_nxt;
      rem_refused_r  <= rem_bad;
      init_refused_r <= init_bad;
      init_ok_r      <= slave_init_req && !init_bad;
      dc_off_r       <= sup_expire && dc_on && off_after;
    end
  end

  // ************************************************************
  // interface supervision timer
  // ************************************************************
  rlw_timer_if sup_if ();
  logic sup_run;
  logic sup_run_d_r;
  logic owner_msg;

  // slaves leave supervision to their master
  assign sup_run = mon_en && !is_slave && (owner_r != rlw_pkg::OWN_NONE);
  // only the owning interface's traffic counts
  assign owner_msg = msg_rx[owner_r];

  assign sup_if.tick    = tick;
  assign sup_if.run     = sup_run;
  assign sup_if.restart = owner_msg;
  assign sup_if.limit   = tmo_act_r;
  assign sup_expire     = sup_if.expire && sup_run;

  // staged value latched only at period end or while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_act_r   <= rlw_pkg::TIMEOUT_RST;
      sup_run_d_r <= 1'b0;
    end else begin
      sup_run_d_r <= sup_run;
      if (!sup_run || sup_if.expire) begin
        tmo_act_r <= tmo_pend_r;
      end
    end
  end

  rlw_timer u_sup_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .t       (sup_if.tmr)
  );

  // ************************************************************
  // master-slave link supervision
  // ************************************************************
  rlw_timer_if ms_if ();
  logic msp_r;

  assign ms_if.tick    = tick;
  assign ms_if.run     = ms_sup_en && ms_running;
  assign ms_if.restart = ms_heartbeat;
  assign ms_if.limit   = rlw_pkg::MS_LINK_TMO_MS;

  rlw_timer u_ms_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .t       (ms_if.tmr)
  );

  // alarm holds until acknowledged; a new loss beats the ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msp_r <= 1'b0;
    end else if (ms_if.expire) begin
      msp_r <= 1'b1;
    end else if (msp_ack) begin
      msp_r <= 1'b0;
    end
  end

  // ************************************************************
  // events and interrupt
  // ************************************************************
  // network timeout is only reported; it gates nothing here
  assign ev_set = {eth_timeout, init_bad, rem_bad, ms_if.expire, sup_expire};
  assign istat_nxt = (istat_r & ~(wr_istat ? hwdata[rlw_pkg::EV_W-1:0] : 5'h00)) | ev_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_r <= 5'h00;
    end else begin
      istat_r <= istat_nxt;
    end
  end

  assign irq = |(istat_r & imask_r);

  // ************************************************************
  // command port gating
  // ************************************************************
  logic front_free;

  assign front_free     = (owner_r == rlw_pkg::OWN_NONE) && !is_slave && !ms_running;
  assign front_rd_grant = 1'b1;
  assign front_wr_grant = front_free;
  // rtu and text framing both pass; front takes the subset in text framing, any command in rtu
  assign cmd_accept = cmd_valid && (!cmd_front
                      || ((cmd_in_subset || cmd_rtu) && (!cmd_write || front_free)));

  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] status_w;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[rlw_pkg::STAT_OWNER_LSB +: 2] = owner_r;
    status_w[rlw_pkg::STAT_DC_ON_BIT]      = dc_on;
    status_w[rlw_pkg::STAT_SUP_RUN_BIT]    = sup_run_d_r;
    status_w[rlw_pkg::STAT_SLAVE_BIT]      = is_slave;
    status_w[rlw_pkg::STAT_MSP_BIT]        = msp_r;
    status_w[rlw_pkg::STAT_MS_RUN_BIT]     = ms_running;
  end

  always_comb begin
    case (haddr[7:0])
      rlw_pkg::CTRL_OFF:     rd_mux = {29'h0000_0000, ctrl_r};
      rlw_pkg::TIMEOUT_OFF:  rd_mux = {16'h0000, tmo_pend_r};
      rlw_pkg::STATUS_OFF:   rd_mux = status_w;
      rlw_pkg::IRQ_STAT_OFF: rd_mux = {27'h000_0000, istat_r};
      rlw_pkg::IRQ_MASK_OFF: rd_mux = {27'h000_0000, imask_r};
      rlw_pkg::ACT_TMO_OFF:  rd_mux = {16'h0000, tmo_act_r};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign remote_owner                  = owner_r;
  assign remote_active                 = (owner_r != rlw_pkg::OWN_NONE);
  assign dc_off_req                    = dc_off_r;
  assign rem_refused                   = rem_refused_r;
  assign slave_init_ok                 = init_ok_r;
  assign slave_init_refused            = init_refused_r;
  assign master_slave_protection_alarm = msp_r;

endmodule : rlw_watchdog

// ===== rlw_monitor.sv
// checker: port-level assertions for the remote link watchdog
`timescale 1ns/1ps
module rlw_monitor (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       rem_req,
  input wire logic [1:0] rem_req_if,
  input wire logic       ms_running,
  input wire logic       is_slave,
  input wire logic       slave_init_req,
  input wire logic       front_rd_grant,
  input wire logic       front_wr_grant,
  input wire logic [1:0] remote_owner,
  input wire logic       remote_active,
  input wire logic       dc_off_req,
  input wire logic       rem_refused,
  input wire logic       slave_init_refused,
  input wire logic       master_slave_protection_alarm
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ************************************************************
  // properties
  // ************************************************************
  property p_rd_grant;
    front_rd_grant;
  endproperty
  a_rd_grant: assert property (p_rd_grant) else $error("front read not granted");
  property p_wr_grant;
    front_wr_grant == (remote_owner == 2'h0 && !is_slave && !ms_running);
  endproperty
  a_wr_grant: assert property (p_wr_grant) else $error("front write grant wrong");
  property p_active;
    remote_active == (remote_owner != 2'h0);
  endproperty
  a_active: assert property (p_active) else $error("remote active flag wrong");
  property p_ms_refuse;
    rem_req && ms_running |=> rem_refused;
  endproperty
  a_ms_refuse: assert property (p_ms_refuse) else $error("remote entry not refused");
  property p_init_refuse;
    slave_init_req && remote_owner == 2'h1 |=> slave_init_refused;
  endproperty
  a_init_refuse: assert property (p_init_refuse) else $error("slave init not refused");
  property p_grant;
    rem_req && rem_req_if != 2'h0 && remote_owner == 2'h0 && !ms_running && !is_slave
      |=> remote_owner == $past(rem_req_if);
  endproperty
  a_grant: assert property (p_grant) else $error("owner not taken");
  property p_dc_off;
    dc_off_req |-> remote_owner == 2'h0 && $past(remote_owner) != 2'h0;
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("output off without expiry");
  property p_slave_quiet;
    is_slave [*4] |-> !dc_off_req;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("expiry while slave");
  // timer expiry is registered, so the link ran two samples back
  property p_alarm_src;
    $rose(master_slave_protection_alarm) |-> $past(ms_running, 2);
  endproperty
  a_alarm_src: assert property (p_alarm_src) else $error("alarm outside link run");
endmodule : rlw_monitor

// ===== rlw_ctrl_model.sv
// model: superior controller and master link sending periodic traffic
`timescale 1ns/1ps
module rlw_ctrl_model (
  input wire logic       hclk,
  input wire logic       msg_en,
  input wire logic [1:0] msg_port,
  input wire logic       hb_en,
  input wire logic [7:0] gap,
  output logic     [3:0] msg_rx,
  output logic           ms_heartbeat
);
  logic [7:0] cnt_r;
  initial begin
    cnt_r = 8'h00;
    msg_rx = 4'h0;
    ms_heartbeat = 1'b0;
  end
  // gap sets how slowly the controller talks
  always @(posedge hclk) begin
    cnt_r <= (cnt_r >= gap) ? 8'h00 : cnt_r + 8'h01;
    msg_rx <= (msg_en && cnt_r == gap) ? (4'h1 << msg_port) : 4'h0;
    ms_heartbeat <= hb_en && cnt_r == gap;
  end
endmodule : rlw_ctrl_model

// ===== tb.sv
// testbench: self-checking scenarios for the remote link watchdog
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, rem_req, rem_release, ms_running, is_slave, slave_init_req;
  logic msp_ack, eth_timeout, dc_on, cmd_valid, cmd_front, cmd_write, cmd_in_subset, cmd_rtu;
  logic msg_en, hb_en, ms_heartbeat, hreadyout, hresp, cmd_accept, front_rd_grant, front_wr_grant;
  logic remote_active, dc_off_req, rem_refused, slave_init_ok, slave_init_refused, alarm, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans, rem_req_if, msg_port, remote_owner;
  logic [2:0]  hsize;
  logic [3:0]  msg_rx;
  int          n_errors, num_checks, cyc, n_off, n_ref, n_irf, n_iok;

  assign hready = hreadyout;
  rlw_watchdog #(.TICK_CYCLES(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .msg_rx(msg_rx), .rem_req(rem_req), .rem_req_if(rem_req_if),
    .rem_release(rem_release), .ms_running(ms_running), .is_slave(is_slave), .slave_init_req(slave_init_req),
    .ms_heartbeat(ms_heartbeat), .msp_ack(msp_ack), .eth_timeout(eth_timeout), .dc_on(dc_on),
    .cmd_valid(cmd_valid), .cmd_front(cmd_front), .cmd_write(cmd_write), .cmd_in_subset(cmd_in_subset),
    .cmd_rtu(cmd_rtu), .cmd_accept(cmd_accept), .front_rd_grant(front_rd_grant),
    .front_wr_grant(front_wr_grant), .remote_owner(remote_owner), .remote_active(remote_active),
    .dc_off_req(dc_off_req), .rem_refused(rem_refused), .slave_init_ok(slave_init_ok),
    .slave_init_refused(slave_init_refused), .master_slave_protection_alarm(alarm), .irq(irq));
  rlw_ctrl_model i_ctrl (.hclk(hclk), .msg_en(msg_en), .msg_port(msg_port), .hb_en(hb_en), .gap(8'h06),
    .msg_rx(msg_rx), .ms_heartbeat(ms_heartbeat));

  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  // ************************************************************
  // event counters and hang guard
  // ************************************************************
  always @(posedge hclk) begin
    if (dc_off_req === 1'b1) n_off++;
    if (rem_refused === 1'b1) n_ref++;
    if (slave_init_refused === 1'b1) n_irf++;
    if (slave_init_ok === 1'b1) n_iok++;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  // ************************************************************
  // bus tasks: caller stands just after a rising edge
  // ************************************************************
  task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0000_00, a};
    htrans <= rlw_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask : ahb_xfer

  task wr(input logic [7:0] a, input logic [31:0] v);
    ahb_xfer(1'b1, a, v);
    @(posedge hclk);
  endtask : wr

  task rd_chk(input string w, input logic [7:0] a, input logic [31:0] e);
    ahb_xfer(1'b0, a, 32'h0000_0000);
    chk(w, e, d);
  endtask : rd_chk

  task take(input logic [1:0] ifc);
    rem_req <= 1'b1;
    rem_req_if <= ifc;
    @(posedge hclk);
    rem_req <= 1'b0;
    @(posedge hclk);
  endtask : take

  task wait_free(input int n);
    for (int i = 0; i < n && remote_owner !== 2'h0; i++) @(posedge hclk);
  endtask : wait_free

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs();
    rd_chk("ctrl", rlw_pkg::CTRL_OFF, 32'h0000_0004);
    rd_chk("timeout", rlw_pkg::TIMEOUT_OFF, 32'h0000_03E8);
    rd_chk("mask", rlw_pkg::IRQ_MASK_OFF, 32'h0000_0000);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    chk("okay", 32'h0, hresp);
  endtask : t_regs

  task t_expire_off();
    wr(rlw_pkg::TIMEOUT_OFF, 32'h0000_0003);
    wr(rlw_pkg::CTRL_OFF, 32'h0000_0003);
    dc_on <= 1'b1;
    // traffic first, so the short period never runs dry
    msg_port <= 2'h1;
    msg_en <= 1'b1;
    take(2'h1);
    chk("owner", 32'h1, remote_owner);
    wr(rlw_pkg::TIMEOUT_OFF, 32'h0000_0014);
    rd_chk("active tmo", rlw_pkg::ACT_TMO_OFF, 32'h0000_0003);
    repeat (60) @(posedge hclk);
    chk("owner kept", 32'h1, remote_owner);
    msg_port <= 2'h2;
    wait_free(40);
    chk("owner freed", 32'h0, remote_owner);
    msg_en <= 1'b0;
    @(posedge hclk);
    chk("off pulses", 32'h1, n_off);
    rd_chk("istat", rlw_pkg::IRQ_STAT_OFF, 32'h0000_0001);
    rd_chk("new tmo", rlw_pkg::ACT_TMO_OFF, 32'h0000_0014);
    chk("irq masked", 32'h0, irq);
    wr(rlw_pkg::IRQ_MASK_OFF, 32'h0000_0001);
    chk("irq on", 32'h1, irq);
    wr(rlw_pkg::IRQ_STAT_OFF, 32'h0000_0001);
    chk("irq cleared", 32'h0, irq);
  endtask : t_expire_off

  task t_expire_keep();
    wr(rlw_pkg::CTRL_OFF, 32'h0000_0001);
    take(2'h3);
    eth_timeout <= 1'b1;
    @(posedge hclk);
    eth_timeout <= 1'b0;
    repeat (60) @(posedge hclk);
    chk("long tmo owner", 32'h3, remote_owner);
    wait_free(120);
    chk("owner freed 2", 32'h0, remote_owner);
    chk("kept on", 32'h1, n_off);
    rd_chk("eth ev", rlw_pkg::IRQ_STAT_OFF, 32'h0000_0011);
  endtask : t_expire_keep

  task t_slave();
    take(2'h1);
    slave_init_req <= 1'b1;
    @(posedge hclk);
    slave_init_req <= 1'b0;
    is_slave <= 1'b1;
    repeat (150) @(posedge hclk);
    chk("slave owner", 32'h1, remote_owner);
    chk("init refused", 32'h1, n_irf);
    is_slave <= 1'b0;
    rem_release <= 1'b1;
    @(posedge hclk);
    rem_release <= 1'b0;
    slave_init_req <= 1'b1;
    @(posedge hclk);
    slave_init_req <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("released", 32'h0, remote_owner);
    chk("init ok", 32'h1, n_iok);
  endtask : t_slave

  task t_cmds();
    cmd_valid <= 1'b1;
    cmd_front <= 1'b1;
    @(posedge hclk);
    chk("full cmd", 32'h0, cmd_accept);
    cmd_rtu <= 1'b1;
    @(posedge hclk);
    chk("rtu cmd", 32'h1, cmd_accept);
    cmd_rtu <= 1'b0;
    cmd_in_subset <= 1'b1;
    cmd_write <= 1'b1;
    take(2'h1);
    chk("held write", 32'h0, cmd_accept);
    rem_release <= 1'b1;
    @(posedge hclk);
    rem_release <= 1'b0;
    @(posedge hclk);
    chk("free write", 32'h1, cmd_accept);
    cmd_front <= 1'b0;
    cmd_in_subset <= 1'b0;
    @(posedge hclk);
    chk("rear cmd", 32'h1, cmd_accept);
  endtask : t_cmds

  task t_master_link();
    wr(rlw_pkg::CTRL_OFF, 32'h0000_0004);
    ms_running <= 1'b1;
    take(2'h1);
    @(posedge hclk);
    chk("ms refuse", 32'h1, n_ref);
    chk("ms owner", 32'h0, remote_owner);
    hb_en <= 1'b1;
    repeat (600) @(posedge hclk);
    chk("alarm quiet", 32'h0, alarm);
    hb_en <= 1'b0;
    for (int i = 0; i < 500 && alarm !== 1'b1; i++) @(posedge hclk);
    chk("alarm", 32'h1, alarm);
    rd_chk("status", rlw_pkg::STATUS_OFF, 32'h0000_0064);
    msp_ack <= 1'b1;
    @(posedge hclk);
    msp_ack <= 1'b0;
    ms_running <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("alarm ack", 32'h0, alarm);
    rd_chk("ms ev", rlw_pkg::IRQ_STAT_OFF, 32'h0000_001F);
  endtask : t_master_link

  initial begin
    {hsel, hwrite, rem_req, rem_release, ms_running, is_slave, slave_init_req, msp_ack} = 8'h00;
    {eth_timeout, dc_on, cmd_valid, cmd_front, cmd_write, cmd_in_subset, cmd_rtu, msg_en, hb_en} = 9'h000;
    {haddr, hwdata, htrans, rem_req_if, msg_port} = 70'h0;
    hsize = 3'h2;
    {n_errors, num_checks, cyc, n_off, n_ref, n_irf, n_iok} = '0;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_expire_off();
    t_expire_keep();
    t_slave();
    t_cmds();
    t_master_link();
    stop_test();
  end
endmodule : tb

bind rlw_watchdog rlw_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .rem_req(rem_req),
  .rem_req_if(rem_req_if), .ms_running(ms_running), .is_slave(is_slave), .slave_init_req(slave_init_req),
  .front_rd_grant(front_rd_grant), .front_wr_grant(front_wr_grant), .remote_owner(remote_owner),
  .remote_active(remote_active), .dc_off_req(dc_off_req), .rem_refused(rem_refused),
  .slave_init_refused(slave_init_refused), .master_slave_protection_alarm(master_slave_protection_alarm));
